// [logic/arbi_device_end.sv]
// controller side of the add-on register port: decode, registers, irq
`timescale 1ns/1ps
module arbi_device_end (
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    arbi_if.dev                              bus,
    input  wire logic                        pci_rst_n,
    input  wire logic                        mbox_event,
    input  wire logic                        fifo_event,
    input  wire logic [arbi_pkg::DATA_W-1:0] pt_addr,
    input  wire logic                        mcs_we,
    input  wire logic [arbi_pkg::DATA_W-1:0] mcs_wdata,
    output logic      [arbi_pkg::DATA_W-1:0] mailbox_to_pci,
    output logic      [arbi_pkg::DATA_W-1:0] fifo_to_pci,
    output logic                             fifo_to_pci_stb,
    output logic      [arbi_pkg::DATA_W-1:0] pt_data_to_pci
);
    import arbi_pkg::*;

    logic [CNT_W-1:0]    div_cnt;
    logic                bclk;
    logic                bclk_rise;
    logic                rst_out_n;
    logic                irq_pend;
    logic                irq_n_r;
    logic [31:0]         dq_o_r;
    logic                dq_oe_r;

    // one-cycle-old copies: the strobe release edge is seen a cycle late,
    // so address, enables and data are taken from before the release
    logic                sel_q;
    logic                rd_q;
    logic                wr_q;
    logic [4:0]          adr_q;
    logic [3:0]          be_q;
    logic [31:0]         dq_q;

    logic [31:0]         mailbox;
    logic [31:0]         pt_data;
    logic [31:0]         fifo_word;
    logic [31:0]         master_cs;
    logic [INT_SRCS-1:0] int_src;
    logic [INT_SRCS-1:0] int_en;
    logic                fifo_loaded;
    logic [23:0]         gen_scratch;

    // ---------------- buffered bus clock divider
    wire                 div_wrap = (div_cnt == CNT_W'(BCLK_HALF_CYC - 1));

    // square wave at 250/8 MHz, under the 33 MHz ceiling
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt   <= '0;
            bclk      <= 1'b0;
            bclk_rise <= 1'b0;
        end else begin
            div_cnt   <= div_wrap ? '0 : div_cnt + 1'b1;
            bclk      <= div_wrap ? ~bclk : bclk;
            bclk_rise <= div_wrap & ~bclk;
        end
    end

    // ---------------- access decode
    // width pin picks the data path
    wire                 w16       = bus.width_16;
    wire                 sel_now   = ~bus.select_n;

    function automatic logic is_sync_reg(input logic [4:0] a);
        return (a == REG_FIFO) || (a == REG_PT_DATA) || (a == REG_GEN_CS);
    endfunction

    // strobe release edge for ordinary registers
    wire                 async_wr  = wr_q & bus.wr_n & sel_q & ~is_sync_reg(adr_q);
    // bus-clock sampled writes for FIFO, passthru, general
    // one word per rise while the strobe stays low
    wire                 sync_wr   = bclk_rise & sel_now & ~bus.wr_n
                                     & is_sync_reg(bus.reg_addr);
    wire                 wr_go     = async_wr | sync_wr;
    wire [4:0]           w_adr     = sync_wr ? bus.reg_addr : adr_q;
    wire [3:0]           w_be_n    = sync_wr ? bus.byte_lane_enables_n : be_q;
    wire [31:0]          w_dq      = sync_wr ? bus.dq : dq_q;

    // in 16-bit mode lane 3 enable is the half select, lane 2 unused
    wire                 w_half    = w_be_n[3];
    wire [3:0]           lanes     = w16 ? (w_half ? {~w_be_n[1:0], 2'b00}
                                                   : {2'b00, ~w_be_n[1:0]})
                                         : ~w_be_n;
    // 16-bit data arrives on the low lines only
    wire [31:0]          w_data    = w16 ? {w_dq[15:0], w_dq[15:0]} : w_dq;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  en);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < LANES; i++) begin
            if (en[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    wire                 wr_mailbox = wr_go & (w_adr == REG_MAILBOX);
    wire                 wr_fifo    = wr_go & (w_adr == REG_FIFO);
    wire                 wr_pt_data = wr_go & (w_adr == REG_PT_DATA);
    wire                 wr_int_cs  = wr_go & (w_adr == REG_INT_CS);
    wire                 wr_gen_cs  = wr_go & (w_adr == REG_GEN_CS);

    wire [31:0]          int_cs_w   = merge(ZERO_WORD, w_data, lanes);
    wire [31:0]          gen_cs_w   = merge({gen_scratch, 8'h00}, w_data, lanes);
    wire [INT_SRCS-1:0]  int_set    = {fifo_event, mbox_event};
    wire [INT_SRCS-1:0]  int_clr    = wr_int_cs ? int_cs_w[INT_SRC_LSB +: INT_SRCS] : '0;

    // read start with chip select is what counts as an acknowledge
    wire                 rd_start   = sel_now & ~bus.rd_n & ~rd_q;
    // any access to the interrupt register acknowledges
    wire                 int_ack    = wr_int_cs | (rd_start & (bus.reg_addr == REG_INT_CS));
    wire                 int_fire   = |(int_set & int_en);

    // ---------------- read mux
    wire [31:0]          int_cs_rd  = {16'h0000, 6'h00, int_en, 6'h00, int_src};
    wire [31:0]          gen_cs_rd  = {gen_scratch, 6'h00, fifo_loaded, w16};
    logic [31:0]         rsel;
    always_comb begin
        unique case (bus.reg_addr)
            REG_MAILBOX:   rsel = mailbox;
            REG_FIFO:      rsel = fifo_word;
            REG_PT_ADDR:   rsel = pt_addr;
            REG_PT_DATA:   rsel = pt_data;
            REG_INT_CS:    rsel = int_cs_rd;
            REG_GEN_CS:    rsel = gen_cs_rd;
            REG_MASTER_CS: rsel = master_cs;
            default:       rsel = ZERO_WORD;
        endcase
    end
    // high word chosen by the half select input
    wire                 r_half     = bus.byte_lane_enables_n[3];
    // upper lines held at zero in 16-bit reads
    wire [31:0]          rd_word    = w16 ? {ZERO_HALF, r_half ? rsel[31:16] : rsel[15:0]}
                                          : rsel;

    // ---------------- pin sampling
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= 1'b0;
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            adr_q <= 5'h00;
            be_q  <= 4'hf;
            dq_q  <= ZERO_WORD;
        end else begin
            sel_q <= sel_now;
            rd_q  <= ~bus.rd_n;
            wr_q  <= ~bus.wr_n;
            adr_q <= bus.reg_addr;
            be_q  <= bus.byte_lane_enables_n;
            dq_q  <= bus.dq;
        end
    end

    // ---------------- data pins
    // drive from the cycle after read strobe and select are both low until a cycle after either rises
    // chip select high keeps the bus floating
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_o_r  <= ZERO_WORD;
            dq_oe_r <= 1'b0;
        end else begin
            dq_o_r  <= rd_word;
            dq_oe_r <= sel_now & ~bus.rd_n;
        end
    end

    // ---------------- operation registers
    // mailbox and enables take contents from before the write strobe release; FIFO, passthru, general at a bus clock rise
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mailbox     <= ZERO_WORD;
            pt_data     <= ZERO_WORD;
            fifo_word   <= ZERO_WORD;
            gen_scratch <= 24'h00_0000;
            int_en      <= '0;
        end else begin
            if (wr_mailbox) begin
                mailbox <= merge(mailbox, w_data, lanes);
            end
            if (wr_pt_data) begin
                pt_data <= merge(pt_data, w_data, lanes);
            end
            if (wr_fifo) begin
                fifo_word <= merge(fifo_word, w_data, lanes);
            end
            if (wr_gen_cs) begin
                gen_scratch <= gen_cs_w[31:GCS_SCR_LSB];
            end
            if (wr_int_cs) begin
                int_en <= merge({22'h00_0000, int_en, 8'h00}, w_data, lanes)
                          [INT_EN_LSB +: INT_SRCS];
            end
        end
    end

    // fifo holding word flag: pci side takes it on the strobe pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_loaded     <= 1'b0;
            fifo_to_pci_stb <= 1'b0;
        end else begin
            fifo_to_pci_stb <= wr_fifo;
            fifo_loaded     <= wr_fifo | (fifo_loaded & ~fifo_to_pci_stb);
        end
    end

    // ---------------- interrupt
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_src  <= '0;
            irq_pend <= 1'b0;
            irq_n_r  <= 1'b1;
        end else begin
            // write-one clears, a new event in the same cycle wins
            int_src  <= (int_src & ~int_clr) | int_set;
            // acknowledge drops the pin until the next event
            irq_pend <= int_fire | (irq_pend & ~int_ack);
            irq_n_r  <= ~(int_fire | (irq_pend & ~int_ack));
        end
    end

    // ---------------- host-side control and buffered reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            master_cs <= ZERO_WORD;
            rst_out_n <= 1'b0;
        end else begin
            if (mcs_we) begin
                master_cs <= mcs_wdata;
            end
            // pci reset or software bit 24 holds local reset
            rst_out_n <= pci_rst_n & ~master_cs[MCS_RESET_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mailbox_to_pci <= ZERO_WORD;
            fifo_to_pci    <= ZERO_WORD;
            pt_data_to_pci <= ZERO_WORD;
        end else begin
            mailbox_to_pci <= mailbox;
            fifo_to_pci    <= fifo_word;
            pt_data_to_pci <= pt_data;
        end
    end

    assign bus.buffered_bus_clock   = bclk;
    assign bus.local_system_reset_n = rst_out_n;
    assign bus.local_irq_n          = irq_n_r;
    assign bus.dev_dq_o             = dq_o_r;
    assign bus.dev_dq_oe            = dq_oe_r;
endmodule

// [inc/arbi_pkg.sv]
// shared constants for the add-on register bus port, both ends
// Functional notes
// - device drives buffered bus clock, up to 33 MHz
// - buffered reset out, toggled by control bit 24
// - active-low local interrupt from mailbox or FIFO
// - accessing interrupt register deasserts the interrupt
// - interrupt sources clear only on written one
// - width pin low 32-bit, high 16-bit
// - 16-bit: lane-3 enable is half select
// - 16-bit: only low sixteen data lines valid
// - five address inputs select the register
// - active-low byte enables choose active lanes
// - local side asserts chip select per access
// - registers latch on strobe rising edge, except FIFO, passthru data and general
// - passthru data and FIFO accesses use bus clock
// - read drives data while strobe low, else floats
// - local side presents address before read strobe
// - async write captures on write strobe rising edge
// - local side avoids async FIFO bursts
// - sync strobes sampled on bus clock; bursts allowed
package arbi_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 5;
    localparam int          LANES         = 4;
    // word indices on the five address inputs
    localparam logic [4:0]  REG_MAILBOX   = 5'h00;
    localparam logic [4:0]  REG_FIFO      = 5'h08;
    localparam logic [4:0]  REG_PT_ADDR   = 5'h0a;
    localparam logic [4:0]  REG_PT_DATA   = 5'h0b;
    localparam logic [4:0]  REG_INT_CS    = 5'h0d;
    localparam logic [4:0]  REG_GEN_CS    = 5'h0e;
    localparam logic [4:0]  REG_MASTER_CS = 5'h0f;
    // field positions
    localparam int          MCS_RESET_BIT = 24;
    localparam int          INT_SRC_LSB   = 0;
    localparam int          INT_EN_LSB    = 8;
    localparam int          INT_SRCS      = 2;
    localparam int          GCS_WIDTH_BIT = 0;
    localparam int          GCS_FIFO_BIT  = 1;
    localparam int          GCS_SCR_LSB   = 8;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [15:0] ZERO_HALF     = 16'h0000;
    // timing
    localparam int          CLK_NS        = 4;
    localparam int          BCLK_MAX_MHZ  = 33;
    localparam int          BCLK_HALF_NS  = (1000 + 2 * BCLK_MAX_MHZ - 1) / (2 * BCLK_MAX_MHZ);
    localparam int          BCLK_HALF_CYC = (BCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int          ASYNC_SETUP_NS  = 8;
    localparam int          ASYNC_ACTIVE_NS = 12;
    localparam int          ASYNC_IDLE_NS   = 8;
    localparam int          SETUP_CYC     = (ASYNC_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          ACTIVE_CYC    = (ASYNC_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          IDLE_CYC      = (ASYNC_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_W         = 4;
endpackage

// [inc/arbi_if.sv]
// pin bundle between the add-on side and the bus controller
`timescale 1ns/1ps
interface arbi_if;
    logic        buffered_bus_clock;
    logic        local_system_reset_n;
    logic        local_irq_n;
    logic        width_16;
    logic        select_n;
    logic        rd_n;
    logic        wr_n;
    logic [3:0]  byte_lane_enables_n;
    logic [4:0]  reg_addr;
    logic [31:0] dev_dq_o;
    logic        dev_dq_oe;
    logic [31:0] host_dq_o;
    logic        host_dq_oe;
    logic [31:0] dq;
    // undriven bus reads as zero here; the bench may model float itself
    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 32'h0000_0000);
    modport dev (
        output buffered_bus_clock, local_system_reset_n, local_irq_n,
        output dev_dq_o, dev_dq_oe,
        input  width_16, select_n, rd_n, wr_n, byte_lane_enables_n, reg_addr, dq
    );
    modport host (
        input  buffered_bus_clock, local_system_reset_n, local_irq_n,
        output host_dq_o, host_dq_oe,
        output width_16, select_n, rd_n, wr_n, byte_lane_enables_n, reg_addr,
        input  dq
    );
endinterface

// [logic/arbi_host_end.sv]
// add-on side master: turns user commands into register port cycles
`timescale 1ns/1ps
module arbi_host_end (
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    arbi_if.host                         bus,
    input  wire logic                    mode_16,
    input  wire logic                    cmd_valid,
    input  wire logic                    cmd_write,
    input  wire logic                    cmd_sync,
    input  wire logic [arbi_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic                    cmd_half,
    input  wire logic [3:0]              cmd_be,
    input  wire logic [arbi_pkg::DATA_W-1:0] cmd_wdata,
    output logic                         cmd_ready,
    output logic                         rsp_valid,
    output logic [arbi_pkg::DATA_W-1:0]  rsp_rdata
);
    import arbi_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RECOVER,
                              ST_SYNC_WAIT, ST_SYNC_BEAT} arbi_hst_t;

    arbi_hst_t          state;
    logic [CNT_W-1:0]   cnt;
    logic               bclk_q;
    logic               is_write;
    logic               sel_r;
    logic               rd_r;
    logic               wr_r;
    logic               mode_r;
    logic [3:0]         be_r;
    logic [4:0]         adr_r;
    logic [31:0]        dq_r;
    logic               dq_oe_r;

    wire                bclk_rise = bus.buffered_bus_clock & ~bclk_q;
    wire                cnt_done  = (cnt == '0);
    // 16-bit: lane 3 enable becomes the half-word select
    wire  [3:0]         be_pins   = mode_16 ? {cmd_half, 1'b1, ~cmd_be[1:0]} : ~cmd_be;
    wire  [31:0]        wd_pins   = mode_16 ? {ZERO_HALF, cmd_wdata[15:0]} : cmd_wdata;
    wire  [31:0]        rd_pins   = mode_r ? {ZERO_HALF, bus.dq[15:0]} : bus.dq;

    assign bus.select_n            = ~sel_r;
    assign bus.rd_n                = ~rd_r;
    assign bus.wr_n                = ~wr_r;
    assign bus.byte_lane_enables_n = be_r;
    assign bus.reg_addr            = adr_r;
    assign bus.host_dq_o           = dq_r;
    assign bus.host_dq_oe          = dq_oe_r;
    assign bus.width_16            = mode_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bclk_q <= 1'b0;
            mode_r <= 1'b0;
        end else begin
            bclk_q <= bus.buffered_bus_clock;
            mode_r <= mode_16;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= ST_IDLE;
            cnt       <= '0;
            is_write  <= 1'b0;
            sel_r     <= 1'b0;
            rd_r      <= 1'b0;
            wr_r      <= 1'b0;
            be_r      <= 4'hf;
            adr_r     <= 5'h00;
            dq_r      <= ZERO_WORD;
            dq_oe_r   <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= ZERO_WORD;
        end else begin
            rsp_valid <= 1'b0;
            cmd_ready <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (cmd_valid && !cmd_ready) begin
                        cmd_ready <= 1'b1;
                        is_write  <= cmd_write;
                        be_r      <= be_pins;
                        adr_r     <= cmd_addr;
                        dq_r      <= wd_pins;
                        dq_oe_r   <= cmd_write;
                        // address and enables settle before strobe
                        state     <= cmd_sync ? ST_SYNC_WAIT : ST_SETUP;
                        cnt       <= CNT_W'(SETUP_CYC - 1);
                        sel_r     <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    if (cnt_done) begin
                        rd_r  <= ~is_write;
                        wr_r  <= is_write;
                        cnt   <= CNT_W'(ACTIVE_CYC - 1);
                        state <= ST_ACTIVE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (cnt_done) begin
                        // write lands on this strobe release
                        rd_r      <= 1'b0;
                        wr_r      <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_rdata <= is_write ? ZERO_WORD : rd_pins;
                        cnt       <= CNT_W'(IDLE_CYC - 1);
                        state     <= ST_RECOVER;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_RECOVER: begin
                    sel_r   <= 1'b0;
                    dq_oe_r <= 1'b0;
                    if (cnt_done) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_SYNC_WAIT: begin
                    // strobes placed right after a bus clock rise
                    if (bclk_rise) begin
                        rd_r  <= ~is_write;
                        wr_r  <= is_write;
                        state <= ST_SYNC_BEAT;
                    end
                end
                ST_SYNC_BEAT: begin
                    // held across exactly one sampling rise
                    if (bclk_rise) begin
                        rd_r      <= 1'b0;
                        wr_r      <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_rdata <= is_write ? ZERO_WORD : rd_pins;
                        cnt       <= CNT_W'(IDLE_CYC - 1);
                        state     <= ST_RECOVER;
                    end
                end
            endcase
        end
    end
endmodule

// [tb/arbi_props.sv]
// pin-level checks on the add-on register port between the two ends
`timescale 1ns/1ps
module arbi_props (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        buffered_bus_clock,
    input wire logic        local_irq_n,
    input wire logic        width_16,
    input wire logic        select_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic [3:0]  byte_lane_enables_n,
    input wire logic [4:0]  reg_addr,
    input wire logic [31:0] dev_dq_o,
    input wire logic        dev_dq_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_bclk_hi;
        $rose(buffered_bus_clock) |-> buffered_bus_clock[*4] ##1 !buffered_bus_clock;
    endproperty
    property p_bclk_lo;
        $fell(buffered_bus_clock) |-> !buffered_bus_clock[*4] ##1 buffered_bus_clock;
    endproperty
    property p_rd_oe;
        $past(!rd_n && !select_n) |-> dev_dq_oe;
    endproperty
    property p_no_drive;
        dev_dq_oe |-> $past(!rd_n && !select_n);
    endproperty
    property p_half_bus;
        dev_dq_oe && width_16 && $past(width_16) |-> dev_dq_o[31:16] == 16'h0000;
    endproperty
    property p_sel_strobe;
        !rd_n || !wr_n |-> !select_n;
    endproperty
    property p_rd_setup;
        $fell(rd_n) |-> !select_n ##1 (!rd_n && $stable(reg_addr));
    endproperty
    // hold window: strobe stays low, address and lanes frozen
    property p_wr_hold;
        $fell(wr_n) |-> ##1 (!wr_n && $stable(reg_addr) && $stable(byte_lane_enables_n))[*2];
    endproperty
    a_bclk_hi: assert property (p_bclk_hi) else $error("bus clock high phase wrong");
    a_bclk_lo: assert property (p_bclk_lo) else $error("bus clock low phase wrong");
    a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
    a_no_drive: assert property (p_no_drive) else $error("data driven unselected");
    a_half_bus: assert property (p_half_bus) else $error("upper lines busy in half mode");
    a_sel_strobe: assert property (p_sel_strobe) else $error("strobe without select");
    a_rd_setup: assert property (p_rd_setup) else $error("read address not held");
    a_wr_hold: assert property (p_wr_hold) else $error("write strobe or address moved");
    c_write: cover property ($rose(wr_n) && !select_n);
    c_half_read: cover property (dev_dq_oe && width_16);
    c_irq: cover property ($fell(local_irq_n));
endmodule

// [tb/arbi_tb_top.sv]
// self-checking bench: host end and device end joined by the pin bundle
`timescale 1ns/1ps
module arbi_tb_top;
    import arbi_pkg::*;
    logic        ref_clk = 0, arst_n = 0, mode_16 = 0, cmd_valid = 0, cmd_write = 0;
    logic        cmd_sync = 0, cmd_half = 0, pci_rst_n = 1, mbox_event = 0, fifo_event = 0;
    logic        mcs_we = 0, cmd_ready, rsp_valid, fifo_to_pci_stb, stb_seen = 0;
    logic [4:0]  cmd_addr = 5'h00;
    logic [3:0]  cmd_be = 4'h0;
    logic [31:0] cmd_wdata = 32'h0000_0000, mcs_wdata = 32'h0000_0000, rd;
    logic [31:0] pt_addr = 32'h1357_9bdf, rsp_rdata, mailbox_to_pci, fifo_to_pci, pt_data_to_pci;
    int          n_errors = 0, total_checks = 0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (fifo_to_pci_stb === 1'b1) stb_seen <= 1'b1;
    arbi_if u_bus ();
    arbi_host_end i_arbi_host_end (.ref_clk(ref_clk), .arst_n(arst_n), .bus(u_bus),
        .mode_16(mode_16), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sync(cmd_sync),
        .cmd_addr(cmd_addr), .cmd_half(cmd_half), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    arbi_device_end i_arbi_device_end (.ref_clk(ref_clk), .arst_n(arst_n), .bus(u_bus),
        .pci_rst_n(pci_rst_n), .mbox_event(mbox_event), .fifo_event(fifo_event),
        .pt_addr(pt_addr), .mcs_we(mcs_we), .mcs_wdata(mcs_wdata),
        .mailbox_to_pci(mailbox_to_pci), .fifo_to_pci(fifo_to_pci),
        .fifo_to_pci_stb(fifo_to_pci_stb), .pt_data_to_pci(pt_data_to_pci));
    arbi_props u_props (.ref_clk(ref_clk), .arst_n(arst_n),
        .buffered_bus_clock(u_bus.buffered_bus_clock), .local_irq_n(u_bus.local_irq_n),
        .width_16(u_bus.width_16), .select_n(u_bus.select_n), .rd_n(u_bus.rd_n),
        .wr_n(u_bus.wr_n), .byte_lane_enables_n(u_bus.byte_lane_enables_n),
        .reg_addr(u_bus.reg_addr), .dev_dq_o(u_bus.dev_dq_o), .dev_dq_oe(u_bus.dev_dq_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus_op(input logic wr, input logic sy, input logic [4:0] a,
                          input logic hf, input logic [3:0] be, input logic [31:0] wd);
        int k;
        {cmd_write, cmd_sync, cmd_addr, cmd_half, cmd_be, cmd_wdata} = {wr, sy, a, hf, be, wd};
        cmd_valid = 1'b1;
        k = 0;
        do begin @(posedge ref_clk); #1; k++; end while (cmd_ready !== 1'b1 && k < 100);
        cmd_valid = 1'b0;
        do begin @(posedge ref_clk); #1; k++; end while (rsp_valid !== 1'b1 && k < 200);
        if (k >= 200) n_errors++;
        rd = rsp_rdata;
        // host idles and the written register settles only after this
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_word();
        bus_op(1, 0, REG_MAILBOX, 0, 4'hf, 32'h1122_3344);
        bus_op(1, 0, REG_MAILBOX, 0, 4'h5, 32'haabb_ccdd);
        bus_op(0, 0, REG_MAILBOX, 0, 4'hf, 32'h0000_0000);
        check(rd, 32'h11bb_33dd);
        check(mailbox_to_pci, 32'h11bb_33dd);
        bus_op(0, 0, REG_PT_ADDR, 0, 4'hf, 32'h0000_0000);
        check(rd, pt_addr);
        bus_op(0, 0, 5'h1f, 0, 4'hf, 32'h0000_0000);
        check(rd, ZERO_WORD);
    endtask
    task automatic t_half();
        mode_16 = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        bus_op(1, 0, REG_MAILBOX, 1, 4'h3, 32'h0000_5566);
        bus_op(0, 0, REG_MAILBOX, 1, 4'h3, 32'h0000_0000);
        check(rd, 32'h0000_5566);
        bus_op(0, 0, REG_MAILBOX, 0, 4'h3, 32'h0000_0000);
        check(rd, 32'h0000_33dd);
        bus_op(0, 1, REG_GEN_CS, 0, 4'h3, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        check(mailbox_to_pci, 32'h5566_33dd);
        mode_16 = 1'b0;
    endtask
    task automatic t_irq();
        bus_op(1, 0, REG_INT_CS, 0, 4'hf, 32'h0000_0100);
        mbox_event = 1'b1;
        @(posedge ref_clk);
        #1;
        mbox_event = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(u_bus.local_irq_n, 1'b0);
        bus_op(0, 0, REG_INT_CS, 0, 4'hf, 32'h0000_0000);
        check(rd, 32'h0000_0101);
        check(u_bus.local_irq_n, 1'b1);
        bus_op(1, 0, REG_INT_CS, 0, 4'hf, 32'h0000_0100);
        bus_op(0, 0, REG_INT_CS, 0, 4'hf, 32'h0000_0000);
        check(rd, 32'h0000_0101);
        bus_op(1, 0, REG_INT_CS, 0, 4'hf, 32'h0000_0101);
        bus_op(0, 0, REG_INT_CS, 0, 4'hf, 32'h0000_0000);
        check(rd, 32'h0000_0100);
    endtask
    task automatic t_sync();
        bus_op(1, 1, REG_FIFO, 0, 4'hf, 32'h0bad_f00d);
        check(fifo_to_pci, 32'h0bad_f00d);
        check(stb_seen, 1'b1);
        bus_op(1, 1, REG_PT_DATA, 0, 4'hf, 32'h2468_ace0);
        check(pt_data_to_pci, 32'h2468_ace0);
    endtask
    task automatic t_rst();
        {mcs_we, mcs_wdata} = {1'b1, 32'h0100_0000};
        @(posedge ref_clk);
        #1;
        mcs_we = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(u_bus.local_system_reset_n, 1'b0);
        {mcs_we, mcs_wdata} = {1'b1, 32'h0000_0000};
        @(posedge ref_clk);
        #1;
        mcs_we = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(u_bus.local_system_reset_n, 1'b1);
        pci_rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(u_bus.local_system_reset_n, 1'b0);
        pci_rst_n = 1'b1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        t_word();
        t_half();
        t_irq();
        t_sync();
        t_rst();
        tally_and_finish();
    end
endmodule
